//--- core/plh_pkg.sv
package plh_pkg;
	// Port-level protocol selection for the handshaked scalar ports
	typedef enum logic [1:0] {
		PLH_TWO_WAY_HANDSHAKE_MODE = 2'h0,
		PLH_ACKNOWLEDGE_ONLY_MODE = 2'h1,
		PLH_VALID_ONLY_MODE = 2'h2,
		PLH_OUTPUT_VALID_ONLY_MODE = 2'h3
	} plh_mode_t;
	localparam int PLH_DATA_W = 32;
	localparam int PLH_ADDR_W = 8;
	localparam int PLH_RAM_LATENCY = 1;
	localparam logic [31:0] PLH_DATA_RESET = 32'h0;
	localparam logic [7:0] PLH_ADDR_RESET = 8'h0;
endpackage

//--- core/plh_if.sv
`timescale 1ns/10ps
// Wires between the synthesized block (dev) and its producer, consumer, RAM and FIFOs (far)
interface plh_if #(parameter int DW = 32, parameter int AW = 8) ();
	logic in_vld;
	logic in_ack;
	logic [DW-1:0] in_data;
	logic out_vld;
	logic out_ack;
	logic [DW-1:0] out_data;
	logic [AW-1:0] ram_address;
	logic ram_ce;
	logic ram_we;
	logic [DW-1:0] ram_write_data;
	logic [DW-1:0] ram_read_data;
	logic fin_empty_n;
	logic fin_read;
	logic [DW-1:0] fin_data;
	logic fout_full_n;
	logic fout_write;
	logic fout_lwr;
	logic [DW-1:0] fout_data;
	modport dev (
		input in_vld, in_data, out_ack, ram_read_data, fin_empty_n, fin_data, fout_full_n,
		output in_ack, out_vld, out_data, ram_address, ram_ce, ram_we, ram_write_data,
		output fin_read, fout_write, fout_lwr, fout_data
	);
	modport far (
		output in_vld, in_data, out_ack, ram_read_data, fin_empty_n, fin_data, fout_full_n,
		input in_ack, out_vld, out_data, ram_address, ram_ce, ram_we, ram_write_data,
		input fin_read, fout_write, fout_lwr, fout_data
	);
endinterface // plh_if

//--- core/plh_device.sv
`timescale 1ns/10ps
// The user side asks for one operation at a time on each port (req a level, held
// until done pulses). Each port is independent so the block logic can overlap them.
module plh_device #(
	parameter plh_pkg::plh_mode_t MODE = plh_pkg::PLH_TWO_WAY_HANDSHAKE_MODE,
	parameter int DW = plh_pkg::PLH_DATA_W,
	parameter int AW = plh_pkg::PLH_ADDR_W,
	parameter int RAM_LAT = plh_pkg::PLH_RAM_LATENCY
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic block_start,
	plh_if.dev link,
	input wire logic in_req,
	output logic in_done,
	output logic [DW-1:0] in_value,
	input wire logic out_req,
	input wire logic [DW-1:0] out_value,
	output logic out_done,
	input wire logic ram_req,
	input wire logic ram_wr,
	input wire logic [AW-1:0] ram_addr,
	input wire logic [DW-1:0] ram_wdata,
	output logic ram_done,
	output logic [DW-1:0] ram_rdata,
	input wire logic fin_req,
	output logic fin_done,
	output logic [DW-1:0] fin_value,
	input wire logic fout_req,
	input wire logic fout_last,
	input wire logic [DW-1:0] fout_value,
	output logic fout_done
);
	import plh_pkg::*;

	// Refuse widths and latencies that the port logic and read pipe cannot serve
	if (DW < 1 || AW < 1 || RAM_LAT < 1 || RAM_LAT > 8) begin : g_bad_param
		$error("plh_device: unsupported parameter values");
	end

	// Started flag: block_start gates every port
	logic run_reg;
	always_ff @(posedge clk) begin
		if (!resetn) run_reg <= 1'b0;
		else if (block_start) run_reg <= 1'b1;
	end

	wire in_has_vld = (MODE == PLH_TWO_WAY_HANDSHAKE_MODE) || (MODE == PLH_VALID_ONLY_MODE);
	wire in_bare = (MODE == PLH_OUTPUT_VALID_ONLY_MODE);
	wire out_has_vld = (MODE != PLH_ACKNOWLEDGE_ONLY_MODE);
	wire out_has_ack = (MODE == PLH_TWO_WAY_HANDSHAKE_MODE) || (MODE == PLH_ACKNOWLEDGE_ONLY_MODE);

	// ---- Scalar input port ----
	// Valid-only mode latches data whenever valid is seen after block_start, even if not asked for yet
	logic held_reg;
	logic [DW-1:0] held_data_reg;
	logic in_ack_reg;
	logic in_done_reg;
	logic [DW-1:0] in_value_reg;
	wire in_want = run_reg && in_req && !in_done_reg;
	wire vo_catch = run_reg && (MODE == PLH_VALID_ONLY_MODE) && link.in_vld;
	wire vo_avail = held_reg || vo_catch;
	wire [DW-1:0] vo_data = vo_catch ? link.in_data : held_data_reg;
	// Two-way waits for valid; ack-only and bare read at once
	wire in_take = in_want && ((MODE == PLH_VALID_ONLY_MODE) ? vo_avail :
		(in_has_vld ? link.in_vld : 1'b1));
	always_ff @(posedge clk) begin
		if (!resetn) begin
			held_reg <= 1'b0;
			held_data_reg <= PLH_DATA_RESET;
		end else if (vo_catch) begin
			held_reg <= !in_take;
			held_data_reg <= link.in_data;
		end else if (in_take) begin
			held_reg <= 1'b0;
		end
	end
	// Ack is combinational in the read cycle so producer sees it with its valid
	assign link.in_ack = in_take && !in_bare && (MODE != PLH_VALID_ONLY_MODE) && resetn;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			in_done_reg <= 1'b0;
			in_value_reg <= PLH_DATA_RESET;
		end else begin
			in_done_reg <= in_take;
			if (in_take) in_value_reg <= (MODE == PLH_VALID_ONLY_MODE) ? vo_data : link.in_data;
		end
	end
	assign in_done = in_done_reg;
	assign in_value = in_value_reg;

	// ---- Scalar output port ----
	logic out_busy_reg;
	logic out_vld_reg;
	logic out_done_reg;
	logic [DW-1:0] out_data_reg;
	wire out_start = run_reg && out_req && !out_busy_reg && !out_done_reg;
	// Held until ack when ack exists; valid-only completes in the write cycle
	wire out_finish = out_busy_reg && (!out_has_ack || link.out_ack);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_busy_reg <= 1'b0;
			out_vld_reg <= 1'b0;
			out_done_reg <= 1'b0;
			out_data_reg <= PLH_DATA_RESET;
		end else begin
			out_done_reg <= out_finish;
			if (out_start) begin
				out_data_reg <= out_value; // Data and valid rise together
				out_vld_reg <= out_has_vld;
				out_busy_reg <= 1'b1;
			end else if (out_finish) begin
				out_vld_reg <= 1'b0; // Dropped on the edge after ack
				out_busy_reg <= 1'b0;
			end
		end
	end
	assign link.out_vld = out_vld_reg;
	assign link.out_data = out_data_reg;
	assign out_done = out_done_reg;

	// ---- RAM port ----
	logic ram_ce_reg;
	logic ram_we_reg;
	logic [AW-1:0] ram_addr_reg;
	logic [DW-1:0] ram_wd_reg;
	logic [RAM_LAT-1:0] rd_pipe_reg;
	logic ram_done_reg;
	logic [DW-1:0] ram_rdata_reg;
	wire ram_idle = !ram_ce_reg && (rd_pipe_reg == '0) && !ram_done_reg;
	wire ram_go = run_reg && ram_req && ram_idle;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ram_ce_reg <= 1'b0;
			ram_we_reg <= 1'b0;
			ram_addr_reg <= PLH_ADDR_RESET;
			ram_wd_reg <= PLH_DATA_RESET;
		end else begin
			ram_ce_reg <= ram_go; // Read: address with ce
			ram_we_reg <= ram_go && ram_wr; // Write: ce, we, address, data in one cycle
			if (ram_go) begin
				ram_addr_reg <= ram_addr;
				ram_wd_reg <= ram_wdata;
			end
		end
	end
	// Read data sampled RAM_LAT cycles after the ce cycle
	wire rd_issue = ram_ce_reg && !ram_we_reg;
	wire rd_land = rd_pipe_reg[RAM_LAT-1];
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_pipe_reg <= '0;
			ram_done_reg <= 1'b0;
			ram_rdata_reg <= PLH_DATA_RESET;
		end else begin
			// Shift form serves a one-stage pipe too, with no reversed part-select
			rd_pipe_reg <= (rd_pipe_reg << 1) | RAM_LAT'(rd_issue);
			ram_done_reg <= rd_land || (ram_ce_reg && ram_we_reg);
			if (rd_land) ram_rdata_reg <= link.ram_read_data;
		end
	end
	assign link.ram_address = ram_addr_reg;
	assign link.ram_ce = ram_ce_reg;
	assign link.ram_we = ram_we_reg;
	assign link.ram_write_data = ram_wd_reg;
	assign ram_done = ram_done_reg;
	assign ram_rdata = ram_rdata_reg;

	// ---- FIFO input ----
	logic fin_done_reg;
	logic [DW-1:0] fin_value_reg;
	// Waits while empty; read strobe only in the consuming cycle
	wire fin_take = run_reg && fin_req && !fin_done_reg && link.fin_empty_n;
	assign link.fin_read = fin_take && resetn;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fin_done_reg <= 1'b0;
			fin_value_reg <= PLH_DATA_RESET;
		end else begin
			fin_done_reg <= fin_take;
			if (fin_take) fin_value_reg <= link.fin_data;
		end
	end
	assign fin_done = fin_done_reg;
	assign fin_value = fin_value_reg;

	// ---- FIFO output ----
	logic fout_busy_reg;
	logic fout_last_reg;
	logic fout_done_reg;
	logic fout_lwr_reg;
	logic [DW-1:0] fout_data_reg;
	wire fout_start = run_reg && fout_req && !fout_busy_reg && !fout_done_reg;
	// Data already on the port; write strobe only while not full
	wire fout_wr = fout_busy_reg && link.fout_full_n;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fout_busy_reg <= 1'b0;
			fout_last_reg <= 1'b0;
			fout_done_reg <= 1'b0;
			fout_lwr_reg <= 1'b0;
			fout_data_reg <= PLH_DATA_RESET;
		end else begin
			fout_done_reg <= fout_wr;
			fout_lwr_reg <= fout_wr && fout_last_reg; // Pulse after final write completes
			if (fout_start) begin
				fout_busy_reg <= 1'b1;
				fout_last_reg <= fout_last;
				fout_data_reg <= fout_value;
			end else if (fout_wr) begin
				fout_busy_reg <= 1'b0;
			end
		end
	end
	assign link.fout_write = fout_wr && resetn;
	assign link.fout_data = fout_data_reg;
	assign link.fout_lwr = fout_lwr_reg;
	assign fout_done = fout_done_reg;
endmodule // plh_device

//--- core/plh_partner.sv
`timescale 1ns/10ps
// Far end: producer, consumer, single-port RAM and two FIFO heads, driven by user-side levels
module plh_partner #(
	parameter int DW = plh_pkg::PLH_DATA_W,
	parameter int AW = plh_pkg::PLH_ADDR_W,
	parameter int RAM_LAT = plh_pkg::PLH_RAM_LATENCY
) (
	input wire logic clk,
	input wire logic resetn,
	plh_if.far link,
	input wire logic prod_offer,
	input wire logic [DW-1:0] prod_value,
	output logic prod_taken,
	input wire logic cons_ready,
	output logic cons_got,
	output logic [DW-1:0] cons_value,
	input wire logic fin_avail,
	input wire logic [DW-1:0] fin_value,
	output logic fin_popped,
	input wire logic fout_space,
	output logic fout_pushed,
	output logic [DW-1:0] fout_value,
	output logic fout_last_seen
);
	import plh_pkg::*;

	// Refuse widths and latencies that the RAM model cannot serve
	if (DW < 1 || AW < 1 || RAM_LAT < 1 || RAM_LAT > 8) begin : g_bad_param
		$error("plh_partner: unsupported parameter values");
	end

	logic [DW-1:0] mem_reg [2**AW];
	logic [DW-1:0] rd_pipe_reg [RAM_LAT];
	logic prod_taken_reg;
	logic cons_got_reg;
	logic [DW-1:0] cons_value_reg;
	logic fin_popped_reg;
	logic fout_pushed_reg;
	logic [DW-1:0] fout_value_reg;
	logic fout_last_reg;

	// Producer drives valid and data straight from prod_offer and prod_value
	assign link.in_vld = prod_offer;
	assign link.in_data = prod_value;
	// Consumer acknowledges whenever it is ready to take
	assign link.out_ack = cons_ready;
	assign link.fin_empty_n = fin_avail;
	assign link.fin_data = fin_value;
	assign link.fout_full_n = fout_space;
	// Read data appears RAM_LAT cycles after the ce cycle
	assign link.ram_read_data = rd_pipe_reg[RAM_LAT-1];

	// RAM array; write with ce and we, read fills the latency pipe
	always_ff @(posedge clk) begin
		if (link.ram_ce && link.ram_we) mem_reg[link.ram_address] <= link.ram_write_data;
		rd_pipe_reg[0] <= mem_reg[link.ram_address];
		for (int i = 1; i < RAM_LAT; i++) rd_pipe_reg[i] <= rd_pipe_reg[i-1];
	end

	// Observed transfers reported to the user side
	always_ff @(posedge clk) begin
		if (!resetn) begin
			prod_taken_reg <= 1'b0;
			cons_got_reg <= 1'b0;
			cons_value_reg <= PLH_DATA_RESET;
			fin_popped_reg <= 1'b0;
			fout_pushed_reg <= 1'b0;
			fout_value_reg <= PLH_DATA_RESET;
			fout_last_reg <= 1'b0;
		end else begin
			prod_taken_reg <= link.in_ack;
			cons_got_reg <= link.out_vld && cons_ready;
			if (link.out_vld && cons_ready) cons_value_reg <= link.out_data;
			fin_popped_reg <= link.fin_read && fin_avail;
			fout_pushed_reg <= link.fout_write && fout_space;
			if (link.fout_write && fout_space) fout_value_reg <= link.fout_data;
			fout_last_reg <= link.fout_lwr;
		end
	end
	assign prod_taken = prod_taken_reg;
	assign cons_got = cons_got_reg;
	assign cons_value = cons_value_reg;
	assign fin_popped = fin_popped_reg;
	assign fout_pushed = fout_pushed_reg;
	assign fout_value = fout_value_reg;
	assign fout_last_seen = fout_last_reg;
endmodule // plh_partner

//--- verification/plh_link_monitor.sv
`timescale 1ns/10ps
// Watches the wires between the two ends; nothing is judged while reset is low
module plh_link_monitor #(
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_vld,
	input wire logic in_ack,
	input wire logic out_vld,
	input wire logic out_ack,
	input wire logic [DW-1:0] out_data,
	input wire logic ram_ce,
	input wire logic ram_we,
	input wire logic fin_empty_n,
	input wire logic fin_read,
	input wire logic fout_full_n,
	input wire logic fout_write,
	input wire logic fout_lwr
);
	default clocking mc @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Handshake relations between strobes and their causes
	chk_ack_needs_vld: assert property (in_ack |-> in_vld)
		else $error("input ack without valid");
	chk_ack_single: assert property (in_ack |=> !in_ack)
		else $error("input ack longer than one cycle");
	chk_out_hold: assert property (out_vld && !out_ack |=> out_vld && $stable(out_data))
		else $error("output not held while unacknowledged");
	chk_vld_drop: assert property (out_vld && out_ack |=> !out_vld)
		else $error("output valid kept after ack");
	chk_ce_pulse: assert property (ram_ce |=> !ram_ce)
		else $error("chip enable longer than one cycle");
	chk_we_with_ce: assert property (ram_we |-> ram_ce)
		else $error("write enable without chip enable");
	chk_read_not_empty: assert property (fin_read |-> fin_empty_n)
		else $error("fifo read while empty");
	chk_write_not_full: assert property (fout_write |-> fout_full_n)
		else $error("fifo write while full");
	chk_lwr_after_write: assert property (fout_lwr |-> $past(fout_write))
		else $error("last write flag without a write");
	chk_reset_quiet: assert property ($rose(resetn) |->
		!(in_ack || out_vld || ram_ce || ram_we || fin_read || fout_write || fout_lwr))
		else $error("strobe active straight after reset");

	// Main traffic seen at least once
	cover property (in_vld && in_ack);
	cover property (out_vld && !out_ack ##1 out_vld && out_ack);
	cover property (fout_lwr);
endmodule // plh_link_monitor

//--- verification/port_level_handshake_interfaces_test.sv
`timescale 1ns/10ps
module port_level_handshake_interfaces_test;
	import plh_pkg::*;
	logic clk = 0, resetn = 0, block_start = 0;
	logic in_req = 0, out_req = 0, ram_req = 0, ram_wr = 0, fin_req = 0, fout_req = 0;
	logic fout_last = 0, prod_offer = 0, cons_ready = 0, fin_avail = 0, fout_space = 0;
	logic in_done, out_done, ram_done, fin_done, fout_done;
	logic prod_taken, cons_got, fin_popped, fout_pushed, fout_last_seen;
	logic [7:0] ram_addr = 8'h0;
	logic [31:0] out_value = 32'h0, ram_wdata = 32'h0, prod_value = 32'h0;
	logic [31:0] far_fin_value = 32'h0, dev_fout_value = 32'h0;
	logic [31:0] in_value, ram_rdata, dev_fin_value, cons_value, far_fout_value;
	logic [31:0] rnd;
	int bad_count = 0, n_checks = 0, cyc = 0;
	int mem [int];
	int aq [$];
	wire [3:1] m_in_done, m_prod_taken, m_out_vld, m_out_done;
	wire [31:0] m_in_value [1:3];

	plh_if #(.DW(32), .AW(8)) link ();
	plh_device #(.MODE(PLH_TWO_WAY_HANDSHAKE_MODE)) u_plh_device (.clk(clk), .resetn(resetn),
		.block_start(block_start), .link(link), .in_req(in_req), .in_done(in_done),
		.in_value(in_value), .out_req(out_req), .out_value(out_value), .out_done(out_done),
		.ram_req(ram_req), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_done(ram_done), .ram_rdata(ram_rdata), .fin_req(fin_req), .fin_done(fin_done),
		.fin_value(dev_fin_value), .fout_req(fout_req), .fout_last(fout_last),
		.fout_value(dev_fout_value), .fout_done(fout_done));
	plh_partner u_plh_partner (.clk(clk), .resetn(resetn), .link(link),
		.prod_offer(prod_offer), .prod_value(prod_value), .prod_taken(prod_taken),
		.cons_ready(cons_ready), .cons_got(cons_got), .cons_value(cons_value),
		.fin_avail(fin_avail), .fin_value(far_fin_value), .fin_popped(fin_popped),
		.fout_space(fout_space), .fout_pushed(fout_pushed), .fout_value(far_fout_value),
		.fout_last_seen(fout_last_seen));
	plh_link_monitor #(.DW(32)) u_plh_link_monitor (.clk(clk), .resetn(resetn),
		.in_vld(link.in_vld), .in_ack(link.in_ack), .out_vld(link.out_vld),
		.out_ack(link.out_ack), .out_data(link.out_data), .ram_ce(link.ram_ce),
		.ram_we(link.ram_we), .fin_empty_n(link.fin_empty_n), .fin_read(link.fin_read),
		.fout_full_n(link.fout_full_n), .fout_write(link.fout_write), .fout_lwr(link.fout_lwr));

	// One more pair per subset mode, sharing the user side; bit m of each vector is mode m
	for (genvar m = 1; m < 4; m++) begin : g_mode
		plh_if #(.DW(32), .AW(8)) link_m ();
		plh_device #(.MODE(plh_mode_t'(m))) u_plh_device (.clk(clk), .resetn(resetn),
			.block_start(block_start), .link(link_m), .in_req(in_req), .in_done(m_in_done[m]),
			.in_value(m_in_value[m]), .out_req(out_req), .out_value(out_value),
			.out_done(m_out_done[m]), .ram_req(ram_req), .ram_wr(ram_wr), .ram_addr(ram_addr),
			.ram_wdata(ram_wdata), .ram_done(), .ram_rdata(), .fin_req(fin_req), .fin_done(),
			.fin_value(), .fout_req(fout_req), .fout_last(fout_last),
			.fout_value(dev_fout_value), .fout_done());
		plh_partner u_plh_partner (.clk(clk), .resetn(resetn), .link(link_m),
			.prod_offer(prod_offer), .prod_value(prod_value), .prod_taken(m_prod_taken[m]),
			.cons_ready(cons_ready), .cons_got(), .cons_value(), .fin_avail(fin_avail),
			.fin_value(far_fin_value), .fin_popped(), .fout_space(fout_space),
			.fout_pushed(), .fout_value(), .fout_last_seen());
		assign m_out_vld[m] = link_m.out_vld;
	end

	// Free-running bench clock, 50 ns period
	always #25 clk = ~clk;

	// A hang is cut short well past the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Random stall; no port may finish while its partner holds back
	task automatic stall();
		rnd = lfsr(rnd);
		repeat (rnd[2:0] + 1) begin
			tick();
			chk(32'({in_done, out_done, fin_done, fout_done}), 32'h0);
		end
	endtask

	task automatic ram_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
		ram_req = 1;
		ram_wr = wr;
		ram_addr = a;
		ram_wdata = d;
		while (ram_done !== 1'b1) tick();
		ram_req = 0;
		if (!wr) chk(ram_rdata, 32'(mem[a]));
		tick();
	endtask

	task automatic test_done();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		rnd = 32'h103db;
		repeat (5) begin
			tick();
			chk(32'({link.in_ack, link.out_vld, link.ram_ce, link.fout_lwr}), 32'h0);
		end
		resetn = 1;
		in_req = 1;
		prod_offer = 1;
		prod_value = rnd;
		repeat (4) begin
			tick();
			chk(32'({in_done, link.in_ack, prod_taken}), 32'h0);
		end
		block_start = 1;
		while (in_done !== 1'b1) tick();
		in_req = 0;
		prod_offer = 0;
		chk(in_value, prod_value);
		$display("start gating test done");
		for (int i = 0; i < 4; i++) begin
			tick();
			in_req = 1;
			rnd = lfsr(rnd);
			prod_value = rnd;
			stall();
			prod_offer = 1;
			while (in_done !== 1'b1) tick();
			in_req = 0;
			prod_offer = 0;
			chk(in_value, prod_value);
			chk(32'(prod_taken), 32'h1);
			out_req = 1;
			out_value = lfsr(rnd);
			stall();
			chk(32'(link.out_vld), 32'h1);
			chk(link.out_data, out_value);
			cons_ready = 1;
			while (out_done !== 1'b1) tick();
			out_req = 0;
			cons_ready = 0;
			chk(cons_value, out_value);
			chk(32'(cons_got), 32'h1);
			fin_req = 1;
			far_fin_value = ~rnd;
			stall();
			fin_avail = 1;
			while (fin_done !== 1'b1) tick();
			fin_req = 0;
			fin_avail = 0;
			chk(dev_fin_value, far_fin_value);
			chk(32'(fin_popped), 32'h1);
			fout_req = 1;
			fout_last = (i == 3);
			dev_fout_value = rnd ^ 32'h5a5a_a5a5;
			stall();
			chk(link.fout_data, dev_fout_value);
			fout_space = 1;
			while (fout_done !== 1'b1) tick();
			fout_req = 0;
			fout_space = 0;
			chk(far_fout_value, dev_fout_value);
			chk(32'(fout_pushed), 32'h1);
			tick();
			chk(32'(fout_last_seen), 32'(i == 3));
			$display("port round %0d done", i);
		end
		// Random writes then read-back against the bench memory model
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			aq.push_back(int'(rnd[7:0]));
			mem[int'(rnd[7:0])] = int'(lfsr(rnd));
			ram_op(1'b1, rnd[7:0], lfsr(rnd));
		end
		foreach (aq[k]) ram_op(1'b0, 8'(aq[k]), 32'h0);
		$display("ram test done");
		// Subset modes: inputs without valid read at once, valid-only keeps an early word
		in_req = 1;
		prod_value = rnd;
		tick();
		chk(32'({m_in_done, in_done}), 32'ha);
		chk(32'(m_prod_taken), 32'h1);
		chk(m_in_value[1], rnd);
		chk(m_in_value[3], rnd);
		in_req = 0;
		prod_offer = 1;
		prod_value = ~rnd;
		tick();
		prod_offer = 0;
		prod_value = rnd;
		tick();
		in_req = 1;
		tick();
		chk(32'({m_in_done, in_done}), 32'he);
		chk(m_in_value[2], ~rnd);
		chk(m_in_value[3], rnd);
		in_req = 0;
		out_req = 1;
		out_value = ~rnd;
		tick();
		chk(32'({m_out_vld, link.out_vld}), 32'hd);
		tick();
		chk(32'({m_out_done, out_done}), 32'hc);
		cons_ready = 1;
		tick();
		chk(32'({m_out_done, out_done}), 32'h3);
		chk(cons_value, ~rnd);
		out_req = 0;
		cons_ready = 0;
		tick();
		$display("mode test done");
		// Mid-run reset with requests pending while the run flag is still set
		resetn = 0;
		in_req = 1;
		prod_offer = 1;
		fin_req = 1;
		fin_avail = 1;
		#2;
		chk(32'({link.in_ack, link.fin_read, link.fout_write}), 32'h0);
		tick();
		chk(32'({link.in_ack, link.fin_read, in_done, fin_done}), 32'h0);
		in_req = 0;
		prod_offer = 0;
		fin_req = 0;
		fin_avail = 0;
		resetn = 1;
		tick();
		tick();
		chk(32'({in_done, fin_done, link.out_vld, link.ram_ce}), 32'h0);
		$display("reset test done");
		test_done();
	end
endmodule // port_level_handshake_interfaces_test
